// File: src/smbus_slave_register_port.sv
// two-wire management bus slave port with register pointer and write strobe
//
// Overview of operation
// - mode strap high at power-up selects address 0101110, level strap ignored.
// - mode strap low selects 0101100 for level low, 0101101 for level high.
// - both strap levels are sampled at power-up; the level strap picks the address only with the mode strap low.
// - address freezes at 8th rising SCL of first matching transfer.
// - start is SDA falling with SCL high; then 7 address bits MSB first, direction.
// - matching address is acked by pulling SDA low before the ninth clock.
// - direction 0 means master writes, 1 means master reads.
// - each byte is nine pulses, eight data bits then acknowledge.
// - direction holds for the whole transfer; a new start changes it.
// - writes carry one or two bytes, reads repeat the selected register until the master nacks.
// - first write byte always loads the register pointer.
// - second write byte is written to the register the pointer selects.
// - pointer keeps its value; a bare read returns the selected register.
// - arbitrary read is a pointer-only write followed by a read.
// - a repeated start is accepted as the beginning of a new transfer.
// - send byte, receive byte and combined read byte are all supported.
// - with timeout enabled, 35 ms of no bus activity releases the bus.
// - timeout is enabled by default; the disable input turns it off.
`timescale 1ns/1ps
`include "smbus_consts.svh"
module smbus_slave_register_port #(
  parameter int unsigned TIMEOUT_CYCLES =
    `SMB_TIMEOUT_MS * (`SMB_CLK_HZ / `SMB_MS_PER_S)
) (
  // system clock, reset, enable
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  // bus clock and data pin
  input  wire logic             scl_clk,
  input  wire logic             sda_in,
  output logic                  sda_out,
  output logic                  sda_oe,
  // address straps
  input  wire logic             address_mode_strap,
  input  wire logic             address_level_strap,
  // configuration
  input  wire logic             bus_timeout_disable,
  // register side
  input  wire smbus_pkg::data8_t rd_data,
  output smbus_pkg::data8_t     reg_ptr,
  output logic                  wr_strobe,
  output smbus_pkg::data8_t     wr_data,
  output smbus_pkg::addr7_t     slave_addr
);
  import smbus_pkg::*;

  // address picked from the strap levels
  function automatic addr7_t strap_addr(input logic mode, input logic level);
    if (mode) begin
      return `SMB_ADDR_FIXED;
    end else if (level) begin
      return `SMB_ADDR_SEL_HIGH;
    end else begin
      return `SMB_ADDR_SEL_LOW;
    end
  endfunction

  // ---------------- bus clock domain ----------------
  logic        abort_q;     // clears the bus-clock byte engine, start toggle and SDA drive (reset or timeout)
  logic        start_tgl_q;
  logic        start_tgl_d;
  link_state_t st_q, st_d;
  logic [3:0]  cnt_q, cnt_d;
  data8_t      sh_q, sh_d;
  logic        hit_q, hit_d;
  logic        rw_q, rw_d;
  logic        ack_q, ack_d;
  logic [1:0]  nbyte_q, nbyte_d;
  data8_t      ptr_q, ptr_d;
  data8_t      wdat_q, wdat_d;
  logic        ptr_tgl_q, ptr_tgl_d;
  logic        wr_tgl_q, wr_tgl_d;
  logic        lock_q, lock_d;
  addr7_t      lkaddr_q, lkaddr_d;
  logic        start_ack_q, start_ack_d;
  data8_t      tx_q, tx_d;
  logic        oe_q, oe_d;
  data8_t      rd_scl;
  addr7_t      sel_scl;
  addr7_t      own;
  data8_t      byte_in;
  addr7_t      sel_q;

  // register data and strap address brought onto the bus clock
  smbus_sync #(.W(15)) u_sync_scl (
    .clk (scl_clk),
    .en  (1'b1),
    .d   ({rd_data, sel_q}),
    .q   ({rd_scl, sel_scl})
  );

  // start detect: SDA falling while SCL high flips the start toggle
  always_comb begin
    start_tgl_d = start_tgl_q ^ scl_clk;
  end

  always_ff @(negedge sda_in or posedge abort_q) begin
    if (abort_q) begin
      start_tgl_q <= 1'b0;
    end else begin
      start_tgl_q <= start_tgl_d;
    end
  end

  // byte engine on rising SCL: sample SDA, count bits, decode bytes
  always_comb begin
    st_d        = st_q;
    cnt_d       = cnt_q;
    sh_d        = sh_q;
    hit_d       = hit_q;
    rw_d        = rw_q;
    ack_d       = ack_q;
    nbyte_d     = nbyte_q;
    ptr_d       = ptr_q;
    wdat_d      = wdat_q;
    ptr_tgl_d   = ptr_tgl_q;
    wr_tgl_d    = wr_tgl_q;
    lock_d      = lock_q;
    lkaddr_d    = lkaddr_q;
    start_ack_d = start_ack_q;
    tx_d        = tx_q;
    own         = lock_q ? lkaddr_q : sel_scl;
    byte_in     = {sh_q[6:0], sda_in};
    if (start_tgl_q != start_ack_q) begin
      // first pulse after any start or repeated start opens a new transfer
      start_ack_d = start_tgl_q;
      st_d        = ls_addr;
      cnt_d       = `SMB_CNT_FIRST;
      sh_d        = {7'h00, sda_in};
      hit_d       = 1'b0;
      nbyte_d     = `SMB_WR_PTR_BYTE;
    end else begin
      case (st_q)
        ls_addr: begin
          if (cnt_q < `SMB_CNT_ACK) begin
            sh_d  = byte_in;
            cnt_d = cnt_q + `SMB_CNT_FIRST;
            if (cnt_q == `SMB_CNT_LAST_BIT) begin
              hit_d = (byte_in[7:1] == own);
              rw_d  = byte_in[0];
              if ((byte_in[7:1] == own) && !lock_q) begin
                lock_d   = 1'b1;
                lkaddr_d = own;
              end
            end
          end else begin
            cnt_d = `SMB_CNT_ZERO;
            if (hit_q) begin
              st_d = rw_q ? ls_read : ls_write;
              tx_d = rd_scl;
            end else begin
              st_d = ls_idle;
            end
          end
        end
        ls_write: begin
          if (cnt_q < `SMB_CNT_ACK) begin
            sh_d  = byte_in;
            cnt_d = cnt_q + `SMB_CNT_FIRST;
            if (cnt_q == `SMB_CNT_LAST_BIT) begin
              ack_d = (nbyte_q < `SMB_WR_MAX_BYTES);
              if (nbyte_q == `SMB_WR_PTR_BYTE) begin
                ptr_d     = byte_in;
                ptr_tgl_d = ~ptr_tgl_q;
              end else if (nbyte_q == `SMB_WR_DATA_BYTE) begin
                wdat_d   = byte_in;
                wr_tgl_d = ~wr_tgl_q;
              end
              if (nbyte_q < `SMB_WR_MAX_BYTES) begin
                nbyte_d = nbyte_q + 2'h1;
              end
            end
          end else begin
            cnt_d = `SMB_CNT_ZERO;
            if (!ack_q) begin
              st_d = ls_idle;
            end
          end
        end
        ls_read: begin
          if (cnt_q < `SMB_CNT_ACK) begin
            cnt_d = cnt_q + `SMB_CNT_FIRST;
          end else begin
            cnt_d = `SMB_CNT_ZERO;
            if (sda_in) begin
              st_d = ls_idle;
            end else begin
              tx_d = rd_scl;
            end
          end
        end
        default: begin
          st_d = ls_idle;
        end
      endcase
    end
  end

  always_ff @(posedge scl_clk or posedge abort_q) begin
    if (abort_q) begin
      st_q        <= ls_idle;
      cnt_q       <= `SMB_CNT_ZERO;
      sh_q        <= 8'h00;
      hit_q       <= 1'b0;
      rw_q        <= 1'b0;
      ack_q       <= 1'b0;
      nbyte_q     <= `SMB_WR_PTR_BYTE;
      ptr_tgl_q   <= 1'b0;
      wr_tgl_q    <= 1'b0;
      start_ack_q <= 1'b0;
      tx_q        <= 8'h00;
    end else begin
      st_q        <= st_d;
      cnt_q       <= cnt_d;
      sh_q        <= sh_d;
      hit_q       <= hit_d;
      rw_q        <= rw_d;
      ack_q       <= ack_d;
      nbyte_q     <= nbyte_d;
      ptr_tgl_q   <= ptr_tgl_d;
      wr_tgl_q    <= wr_tgl_d;
      start_ack_q <= start_ack_d;
      tx_q        <= tx_d;
    end
  end

  // pointer, write data and frozen address survive a timeout abort
  always_ff @(posedge scl_clk) begin
    if (!rst_n) begin
      ptr_q    <= 8'h00;
      wdat_q   <= 8'h00;
      lock_q   <= 1'b0;
      lkaddr_q <= `SMB_ADDR_FIXED;
    end else begin
      ptr_q    <= ptr_d;
      wdat_q   <= wdat_d;
      lock_q   <= lock_d;
      lkaddr_q <= lkaddr_d;
    end
  end

  // SDA drive on falling SCL: acks and read data, released otherwise
  always_comb begin
    oe_d = 1'b0;
    case (st_q)
      ls_addr: oe_d = (cnt_q == `SMB_CNT_ACK) && hit_q;
      ls_write: oe_d = (cnt_q == `SMB_CNT_ACK) && ack_q;
      ls_read: oe_d = (cnt_q < `SMB_CNT_ACK) && !tx_q[~cnt_q[2:0]];
      default: oe_d = 1'b0;
    endcase
  end

  always_ff @(negedge scl_clk or posedge abort_q) begin
    if (abort_q) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= oe_d;
    end
  end

  assign sda_oe = oe_q;

  // ---------------- system clock domain ----------------
  logic                 mode_s, level_s, scl_s, oe_s, ptr_tgl_s, wr_tgl_s;
  logic                 sampled_q, sampled_d;
  addr7_t               sel_d;
  logic                 ptr_seen_q, ptr_seen_d;
  logic                 wr_seen_q, wr_seen_d;
  logic                 scl_seen_q, scl_seen_d;
  data8_t               reg_ptr_q, reg_ptr_d;
  logic                 wr_strobe_q, wr_strobe_d;
  data8_t               wr_data_q, wr_data_d;
  logic [`SMB_TO_W-1:0] to_cnt_q, to_cnt_d;
  logic                 abort_d;
  logic                 sda_out_q;

  // pins and bus-clock levels brought onto the system clock
  smbus_sync #(.W(6)) u_sync_clk (
    .clk (clk),
    .en  (ce),
    .d   ({address_mode_strap, address_level_strap, scl_clk, oe_q, ptr_tgl_q, wr_tgl_q}),
    .q   ({mode_s, level_s, scl_s, oe_s, ptr_tgl_s, wr_tgl_s})
  );

  // strap capture, pointer and write hand-over, bus timeout
  always_comb begin
    sampled_d   = sampled_q;
    sel_d       = sel_q;
    ptr_seen_d  = ptr_tgl_s;
    wr_seen_d   = wr_tgl_s;
    scl_seen_d  = scl_s;
    reg_ptr_d   = reg_ptr_q;
    wr_data_d   = wr_data_q;
    wr_strobe_d = (wr_tgl_s != wr_seen_q);
    abort_d     = 1'b0;
    to_cnt_d    = to_cnt_q;
    if (!sampled_q) begin
      sampled_d = 1'b1;
      sel_d     = strap_addr(mode_s, level_s);
    end
    if ((ptr_tgl_s != ptr_seen_q) || (wr_tgl_s != wr_seen_q)) begin
      reg_ptr_d = ptr_q;
    end
    if (wr_tgl_s != wr_seen_q) begin
      wr_data_d = wdat_q;
    end
    if (bus_timeout_disable || !oe_s || (scl_s != scl_seen_q)) begin
      to_cnt_d = '0;
    end else if (to_cnt_q == `SMB_TO_W'(TIMEOUT_CYCLES - 1)) begin
      to_cnt_d = '0;
      abort_d  = 1'b1;
    end else begin
      to_cnt_d = to_cnt_q + `SMB_TO_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sampled_q   <= 1'b0;
      sel_q       <= `SMB_ADDR_FIXED;
      ptr_seen_q  <= 1'b0;
      wr_seen_q   <= 1'b0;
      scl_seen_q  <= 1'b0;
      reg_ptr_q   <= 8'h00;
      wr_strobe_q <= 1'b0;
      wr_data_q   <= 8'h00;
      to_cnt_q    <= '0;
      abort_q     <= 1'b1;
      sda_out_q   <= 1'b0;
    end else if (ce) begin
      sampled_q   <= sampled_d;
      sel_q       <= sel_d;
      ptr_seen_q  <= ptr_seen_d;
      wr_seen_q   <= wr_seen_d;
      scl_seen_q  <= scl_seen_d;
      reg_ptr_q   <= reg_ptr_d;
      wr_strobe_q <= wr_strobe_d;
      wr_data_q   <= wr_data_d;
      to_cnt_q    <= to_cnt_d;
      abort_q     <= abort_d;
      sda_out_q   <= 1'b0; // open-drain: only ever pulls low
    end
  end

  assign sda_out    = sda_out_q;
  assign reg_ptr    = reg_ptr_q;
  assign wr_strobe  = wr_strobe_q;
  assign wr_data    = wr_data_q;
  assign slave_addr = sel_q;
endmodule

// File: src/smbus_consts.svh
// constants for the two-wire management bus slave port
`ifndef SMBUS_CONSTS_SVH
`define SMBUS_CONSTS_SVH

// slave addresses chosen by the straps
`define SMB_ADDR_FIXED    7'h2e
`define SMB_ADDR_SEL_LOW  7'h2c
`define SMB_ADDR_SEL_HIGH 7'h2d

// bit slots inside one nine-pulse byte
`define SMB_CNT_FIRST     4'h1
`define SMB_CNT_LAST_BIT  4'h7
`define SMB_CNT_ACK       4'h8
`define SMB_CNT_ZERO      4'h0

// write bytes the port accepts in one transfer (pointer + data)
`define SMB_WR_PTR_BYTE   2'h0
`define SMB_WR_DATA_BYTE  2'h1
`define SMB_WR_MAX_BYTES  2'h2

// bus timeout: time in ms and clock rate in Hz
`define SMB_TIMEOUT_MS    35
`define SMB_CLK_HZ        10000000
`define SMB_MS_PER_S      1000
`define SMB_TO_W          19

`endif

// File: src/smbus_pkg.sv
// types shared by the management bus slave port
package smbus_pkg;
  typedef logic [7:0] data8_t;
  typedef logic [6:0] addr7_t;
  typedef enum logic [1:0] {
    ls_idle,
    ls_addr,
    ls_write,
    ls_read
  } link_state_t;
endpackage

// File: src/smbus_sync.sv
// two-stage synchroniser for a bundle of levels
`timescale 1ns/1ps
module smbus_sync #(
  parameter int W = 1
) (
  // clock and freeze
  input  wire logic         clk,
  input  wire logic         en,
  // levels from another domain
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (en) begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// File: testbench/smbus_master_model.sv
// bus master model driving the bus clock and its pull on the data line
`timescale 1ns/1ps
module smbus_master_model (
  // bus clock, still outside frames
  output logic      scl,
  // master pull on the data line and the resolved line
  output logic      sda_low,
  input  wire logic sda
);
  // idle bus: both lines released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // one bit slot: data moves while scl is low, sampled late in the high phase
  task automatic bit_io(input logic b, output logic r);
    #1 sda_low = !b;
    #5 scl = 1'b1;
    #6 r = sda;
    scl = 1'b0;
  endtask
  // start or repeated start, data falls with scl high
  task automatic start();
    #1 sda_low = 1'b0;
    #5 scl = 1'b1;
    #6 sda_low = 1'b1;
    #6 scl = 1'b0;
  endtask
  // stop, data rises with scl high
  task automatic stop();
    #1 sda_low = 1'b1;
    #5 scl = 1'b1;
    #6 sda_low = 1'b0;
    #6;
  endtask
  // eight bits, most significant first
  task automatic send_bits(input logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(v[i], r);
  endtask
  // byte plus the slave acknowledge, low means taken
  task automatic send(input logic [7:0] v, output logic ack);
    send_bits(v);
    bit_io(1'b1, ack);
  endtask
  // byte from the slave, then the master answer
  task automatic recv(input logic nack, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
    bit_io(nack, r);
  endtask
endmodule

// File: testbench/smbus_slave_register_port_checker.sv
// port assertions for the management bus slave port
`timescale 1ns/1ps
module smbus_slave_register_port_checker #(
  parameter int unsigned TIMEOUT_CYCLES = 20
) (
  // clocks and reset
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              ce,
  input wire logic              scl_clk,
  // data pin and configuration
  input wire logic              sda_in,
  input wire logic              sda_out,
  input wire logic              sda_oe,
  input wire logic              bus_timeout_disable,
  // register side
  input wire smbus_pkg::data8_t reg_ptr,
  input wire logic              wr_strobe,
  input wire smbus_pkg::data8_t wr_data,
  input wire smbus_pkg::addr7_t slave_addr
);
  import smbus_pkg::*;
  logic [19:0] cnt_q;
  logic [19:0] cnt_d;
  logic        scl_q;
  logic        scl_d;
  // cycles the port pulls sda while scl stands still
  always_comb begin
    scl_d = scl_clk;
    cnt_d = (sda_oe && !bus_timeout_disable && scl_clk == scl_q) ? cnt_q + 20'h1 : 20'h0;
  end
  always_ff @(posedge clk) begin
    scl_q <= scl_d;
    cnt_q <= rst_n ? cnt_d : 20'h0;
  end
  a_sda_zero: assert property (@(posedge clk) disable iff (!rst_n)
    sda_out == 1'b0) else $error("sda driven high");
  a_oe_pulls: assert property (@(posedge scl_clk) disable iff (!rst_n)
    sda_oe |-> !sda_in) else $error("ack not on wire");
  a_strobe_single: assert property (@(posedge clk) disable iff (!rst_n)
    wr_strobe |=> !wr_strobe [*3]) else $error("extra write strobe");
  a_data_strobe: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(wr_data) |-> wr_strobe) else $error("write data moved alone");
  a_addr_frozen: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n, 2) |-> $stable(slave_addr)) else $error("address moved");
  a_addr_legal: assert property (@(posedge clk) disable iff (!rst_n)
    slave_addr inside {7'h2c, 7'h2d, 7'h2e}) else $error("bad address");
  a_timeout_bound: assert property (@(posedge clk) disable iff (!rst_n)
    cnt_q <= TIMEOUT_CYCLES + 6) else $error("bus not released");
  a_ce_freeze: assert property (@(posedge clk) disable iff (!rst_n)
    !ce |=> $stable(reg_ptr) && $stable(wr_data)) else $error("moved while frozen");
  // main scenarios
  c_write: cover property (@(posedge clk) wr_strobe);
  c_ack: cover property (@(posedge scl_clk) $rose(sda_oe));
  c_stall: cover property (@(posedge clk) cnt_q == 20'ha);
endmodule
bind smbus_slave_register_port smbus_slave_register_port_checker #(
  .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
) u_chk (
  .clk, .rst_n, .ce, .scl_clk, .sda_in, .sda_out, .sda_oe, .bus_timeout_disable,
  .reg_ptr, .wr_strobe, .wr_data, .slave_addr
);

// File: testbench/smbus_slave_register_port_tb.sv
// bench for the management bus slave port with a bus master model
`timescale 1ns/1ps
module smbus_slave_register_port_tb;
  import smbus_pkg::*;
  logic   clk = 1'b0;
  logic   rst_n = 1'b0;
  logic   ce = 1'b1;
  logic   mode = 1'b1;
  logic   level = 1'b0;
  logic   to_dis = 1'b0;
  logic   scl, m_low, sda, oe, ws, a;
  data8_t ptr, wdat, rdat, d;
  addr7_t sadr;
  int     error_cnt = 0;
  int     checked = 0;
  // system clock
  always #50 clk = ~clk;
  // open-drain wire with pull-up, register contents follow the pointer
  assign sda = !(oe | m_low);
  assign rdat = ptr ^ 8'h96;
  smbus_master_model u_m (.scl(scl), .sda_low(m_low), .sda(sda));
  smbus_slave_register_port #(.TIMEOUT_CYCLES(20)) u_dut (
    .clk(clk), .rst_n(rst_n), .ce(ce), .scl_clk(scl), .sda_in(sda), .sda_out(),
    .sda_oe(oe), .address_mode_strap(mode), .address_level_strap(level),
    .bus_timeout_disable(to_dis), .rd_data(rdat), .reg_ptr(ptr), .wr_strobe(ws),
    .wr_data(wdat), .slave_addr(sadr));
  task automatic report_and_stop();
    if (error_cnt == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic chk1(input logic e, input logic g);
    chk8({7'h00, e}, {7'h00, g});
  endtask
  task automatic do_reset(input logic m, input logic l);
    @(negedge clk);
    rst_n = 1'b0;
    mode = m;
    level = l;
    // bus clock ticks in reset clear the state kept on the bus clock
    repeat (4) u_m.bit_io(1'b1, a);
    u_m.stop();
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
  endtask
  task automatic wait_strobe();
    int n;
    n = 0;
    while (ws !== 1'b1 && n < 30) begin
      @(negedge clk);
      n++;
    end
    chk1(1'b1, ws);
    if (n == 30) report_and_stop();
  endtask
  task automatic t_straps();
    do_reset(1'b1, 1'b1);
    chk8(8'h2e, {1'b0, sadr});
    do_reset(1'b0, 1'b0);
    chk8(8'h2c, {1'b0, sadr});
    do_reset(1'b0, 1'b1);
    chk8(8'h2d, {1'b0, sadr});
  endtask
  task automatic t_nomatch();
    u_m.start();
    u_m.send({7'h2e, 1'b0}, a);
    chk1(1'b1, a);
    u_m.stop();
  endtask
  task automatic t_write();
    @(negedge clk);
    mode = 1'b1;
    u_m.start();
    u_m.send({7'h2d, 1'b0}, a);
    chk1(1'b0, a);
    u_m.send(8'h5a, a);
    chk1(1'b0, a);
    #1000;
    u_m.send(8'ha7, a);
    chk1(1'b0, a);
    u_m.send(8'h11, a);
    chk1(1'b1, a);
    u_m.stop();
    wait_strobe();
    chk8(8'ha7, wdat);
    chk8(8'h5a, ptr);
    chk8(8'h2d, {1'b0, sadr});
  endtask
  task automatic t_read();
    u_m.start();
    u_m.send({7'h2d, 1'b0}, a);
    u_m.send(8'h3c, a);
    chk1(1'b0, a);
    #1000;
    u_m.start();
    u_m.send({7'h2d, 1'b1}, a);
    chk1(1'b0, a);
    u_m.recv(1'b1, d);
    chk8(8'h3c ^ 8'h96, d);
    #2;
    chk1(1'b0, oe);
    u_m.stop();
  endtask
  task automatic t_recv();
    @(negedge clk);
    ce = 1'b0;
    repeat (3) @(negedge clk);
    ce = 1'b1;
    u_m.start();
    u_m.send({7'h2d, 1'b1}, a);
    u_m.recv(1'b1, d);
    chk8(8'h3c ^ 8'h96, d);
    u_m.stop();
  endtask
  task automatic t_timeout();
    @(negedge clk);
    to_dis = 1'b1;
    u_m.start();
    u_m.send_bits({7'h2d, 1'b0});
    repeat (40) @(negedge clk);
    chk1(1'b1, oe);
    to_dis = 1'b0;
    repeat (40) @(negedge clk);
    chk1(1'b0, oe);
    u_m.stop();
  endtask
  // main sequence
  initial begin
    t_straps();
    t_nomatch();
    t_write();
    t_read();
    t_recv();
    t_timeout();
    report_and_stop();
  end
endmodule
